//--- design/wsc_setpoint_comparator.sv
// Purpose: Setpoint evaluation and batch sequencing for a weighing controller.
// Assumes: Samples come from logic on clk; the start pin is async.
// Notes:   Setpoints are scanned one per cycle after each sample.
`timescale 1ns/1ps
`default_nettype none

module wsc_setpoint_comparator #(
  parameter int N           = 20,
  parameter int WW          = 24,
  parameter int TICK_CYCLES = wsc_pkg::TICK_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic [8:0]    addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic [31:0]        rdata,
  input  wire logic          sample_valid,
  input  wire logic [WW-1:0] weight,
  input  wire logic          standstill,
  input  wire logic          batch_start_input,
  output logic [N-1:0]       dout_n,
  output logic               clear_total,
  output logic               clear_tare,
  output logic               batch_busy
);
  localparam int E  = WW + 4;
  localparam int LW = E + 12;
  localparam int VW = wsc_pkg::VW;
  localparam logic signed [LW-1:0] FS_S = LW'(wsc_pkg::FSCALE);
  localparam logic signed [LW-1:0] VM_S = LW'($signed({1'b0, wsc_pkg::VAL_MAX}));

  // ------------------------------------------------------------
  // Start pin synchroniser
  // ------------------------------------------------------------
  logic s1, s2, s3, start_lvl, next_start_lvl, pin_ev, next_pin_ev;

  // Level only moves once the last two stages agree
  always_comb begin
    next_start_lvl = (s2 == s3) ? s3 : start_lvl;
    next_pin_ev    = next_start_lvl & ~start_lvl;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      start_lvl <= 1'b0;
      pin_ev <= 1'b0;
    end else if (ce) begin
      s1 <= batch_start_input;
      s2 <= s1;
      s3 <= s2;
      start_lvl <= next_start_lvl;
      pin_ev <= next_pin_ev;
    end
  end

  // ------------------------------------------------------------
  // Tenth-second tick
  // ------------------------------------------------------------
  logic [31:0] tick_cnt, next_tick_cnt;
  logic        tick, next_tick;

  always_comb begin
    next_tick     = (tick_cnt == 32'(TICK_CYCLES - 1));
    next_tick_cnt = next_tick ? 32'h00000000 : tick_cnt + 32'h00000001;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (ce) begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // ------------------------------------------------------------
  // Setpoint table, scan and batch sequencer
  // ------------------------------------------------------------
  logic [VW-1:0] val [N], band [N], hyst [N], amt [N];
  logic [VW-1:0] next_val [N], next_band [N], next_hyst [N], next_amt [N];
  logic [9:0]    fac [N], next_fac [N];
  logic [15:0]   stl [N], lrn [N], lcnt [N];
  logic [15:0]   next_stl [N], next_lrn [N], next_lcnt [N];
  logic [4:0]    refn [N], next_refn [N];
  logic [wsc_pkg::MISC_W-1:0] misc [N], next_misc [N];
  logic [N-1:0]  sat, next_sat, memv, raw, next_dout;
  logic [1:0]    mode, next_mode;
  wsc_pkg::wsc_state_type st, next_st;
  logic [4:0]    cur, next_cur, scan_idx, next_scan_idx;
  logic          scan_on, next_scan_on;
  logic [WW-1:0] w_cap, next_w_cap;
  logic [19:0]   tmr, next_tmr;
  logic [15:0]   bcnt, next_bcnt;
  logic signed [E-1:0] set_tgt, next_set_tgt;
  logic          set_low, next_set_low;
  logic          p_tot, p_tar, next_p_tot, next_p_tar;
  logic          next_clear_total, next_clear_tare;
  logic [31:0]   next_rdata;

  // Per-entry membership and output before polarity
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sp
      assign memv[g] = misc[g][wsc_pkg::M_MEMBER];
      assign raw[g]  = memv[g] ? (st != wsc_pkg::WSC_IDLE && cur == 5'(g)) : sat[g];
      assign next_dout[g] = ~(raw[g] ^ misc[g][wsc_pkg::M_INV]);
    end
  endgenerate

  // Lowest member index at or above the start point
  function automatic logic [5:0] seek(input logic [N-1:0] v, input int from);
    logic [5:0] r;
    r = 6'h00;
    for (int k = N - 1; k >= 0; k--) begin
      if (k >= from && v[k]) r = {1'b1, 5'(k)};
    end
    return r;
  endfunction

  always_comb begin
    logic [4:0] i, ri, sp, c;
    logic [3:0] fld;
    logic [1:0] kind, trip;
    logic signed [E-1:0] w_s, t_s, cut_s, hb_s, bd_s, lo_s, hi_s, err;
    logic signed [LW-1:0] ld, na;
    logic [39:0] prod;
    logic [VW-1:0] wv;
    logic cond, adv, fin, go, set_tot, set_tar;
    logic [5:0] nx;
    i = scan_idx; ri = 5'h00; sp = addr[8:4]; fld = addr[3:0]; c = cur;
    kind = 2'h0; trip = 2'h0; w_s = '0; t_s = '0; cut_s = '0; hb_s = '0;
    bd_s = '0; lo_s = '0; hi_s = '0; err = '0; ld = '0; na = '0; prod = '0;
    wv = wdata[VW-1:0]; cond = 1'b0; adv = 1'b0; fin = 1'b0; go = 1'b0; nx = 6'h00;
    next_val = val; next_band = band; next_hyst = hyst; next_amt = amt;
    next_fac = fac; next_stl = stl; next_lrn = lrn; next_lcnt = lcnt;
    next_refn = refn; next_misc = misc; next_sat = sat; next_mode = mode;
    next_st = st; next_cur = cur; next_scan_idx = scan_idx; next_scan_on = scan_on;
    next_w_cap = w_cap; next_tmr = tmr; next_bcnt = bcnt; next_set_tgt = set_tgt;
    next_set_low = set_low; set_tot = 1'b0; set_tar = 1'b0;
    next_rdata = 32'h00000000;

    // Register writes, each value but settle, misc and mode clamped to its legal span
    if (wr && sp == wsc_pkg::GLOBAL_SP) begin
      if (fld == wsc_pkg::G_MODE) next_mode = wdata[1:0];
      if (fld == wsc_pkg::G_START && wdata[0]) go = 1'b1;
    end else if (wr && 32'(sp) < N) begin
      case (fld)
        wsc_pkg::F_VALUE: begin
          kind = misc[sp][wsc_pkg::M_KIND +: 2];
          if (kind == wsc_pkg::KIND_TIME || kind == wsc_pkg::KIND_COUNT) begin
            next_val[sp] = (wv > wsc_pkg::CNT_MAX) ? wsc_pkg::CNT_MAX : wv;
          end else begin
            next_val[sp] = (wv > wsc_pkg::VAL_MAX) ? wsc_pkg::VAL_MAX : wv;
          end
        end
        wsc_pkg::F_BAND:   next_band[sp] = (wv > wsc_pkg::VAL_MAX) ? wsc_pkg::VAL_MAX : wv;
        wsc_pkg::F_HYST:   next_hyst[sp] = (wv > wsc_pkg::VAL_MAX) ? wsc_pkg::VAL_MAX : wv;
        wsc_pkg::F_AMOUNT: next_amt[sp]  = (wv > wsc_pkg::VAL_MAX) ? wsc_pkg::VAL_MAX : wv;
        wsc_pkg::F_FACTOR: next_fac[sp]  = (wdata[9:0] > wsc_pkg::FAC_MAX || wdata[31:10] != '0)
                                           ? wsc_pkg::FAC_MAX : wdata[9:0];
        wsc_pkg::F_SETTLE: next_stl[sp]  = wdata[15:0];
        wsc_pkg::F_LEARN:  next_lrn[sp]  = (wdata[15:0] == 16'h0000) ? wsc_pkg::LRN_DEF
                                           : wdata[15:0];
        wsc_pkg::F_REF: begin
          if (wdata[4:0] == 5'h00) next_refn[sp] = wsc_pkg::REF_DEF;
          else if (32'(wdata[4:0]) > N) next_refn[sp] = 5'(N);
          else next_refn[sp] = wdata[4:0];
        end
        wsc_pkg::F_MISC:   next_misc[sp] = wdata[wsc_pkg::MISC_W-1:0];
        default: ;
      endcase
    end

    // Register reads, answered one cycle later
    if (rd && sp == wsc_pkg::GLOBAL_SP) begin
      case (fld)
        wsc_pkg::G_MODE:   next_rdata = {30'h00000000, mode};
        wsc_pkg::G_STATUS: next_rdata = {bcnt, 8'h00, 1'b0, st == wsc_pkg::WSC_SETTLE,
                                         st != wsc_pkg::WSC_IDLE, cur};
        wsc_pkg::G_SAT:    next_rdata = 32'(sat);
        default:           next_rdata = 32'h00000000;
      endcase
    end else if (rd && 32'(sp) < N) begin
      case (fld)
        wsc_pkg::F_VALUE:  next_rdata = 32'(val[sp]);
        wsc_pkg::F_BAND:   next_rdata = 32'(band[sp]);
        wsc_pkg::F_HYST:   next_rdata = 32'(hyst[sp]);
        wsc_pkg::F_AMOUNT: next_rdata = 32'(amt[sp]);
        wsc_pkg::F_FACTOR: next_rdata = 32'(fac[sp]);
        wsc_pkg::F_SETTLE: next_rdata = 32'(stl[sp]);
        wsc_pkg::F_LEARN:  next_rdata = 32'(lrn[sp]);
        wsc_pkg::F_REF:    next_rdata = 32'(refn[sp]);
        wsc_pkg::F_MISC:   next_rdata = 32'(misc[sp]);
        default:           next_rdata = 32'h00000000;
      endcase
    end

    // A new sample restarts the scan from setpoint zero
    if (sample_valid) begin
      next_w_cap = weight;
      next_scan_on = 1'b1;
      next_scan_idx = 5'h00;
    end else if (scan_on) begin
      next_scan_on = (32'(scan_idx) < N - 1);
      next_scan_idx = scan_idx + 5'h01;
    end

    if (tick && st != wsc_pkg::WSC_IDLE && tmr != 20'hFFFFF) next_tmr = tmr + 20'h00001;

    // Evaluate one setpoint against the captured sample
    if (scan_on) begin
      kind = misc[i][wsc_pkg::M_KIND +: 2];
      trip = misc[i][wsc_pkg::M_TRIP +: 2];
      ri = refn[i] - 5'h01;
      w_s = $signed({4'h0, w_cap});
      if (kind == wsc_pkg::KIND_REL) begin
        prod = 40'(val[i]) * 40'(val[ri]) / 40'(wsc_pkg::PCT);
        t_s = $signed({1'b0, prod[E-2:0]});
      end else begin
        t_s = E'($signed({1'b0, val[i]}));
      end
      if (misc[i][wsc_pkg::M_CUT +: 2] != wsc_pkg::CUT_OFF) cut_s = E'($signed({1'b0, amt[i]}));
      hb_s = sat[i] ? '0 : E'($signed({1'b0, hyst[i]}));
      bd_s = E'($signed({1'b0, band[i]}));
      lo_s = t_s - bd_s;
      hi_s = t_s + bd_s;
      case (trip)
        wsc_pkg::TRIP_HIGHER: cond = (w_s >= t_s - cut_s + hb_s);
        wsc_pkg::TRIP_LOWER:  cond = (w_s < t_s + cut_s - hb_s);
        wsc_pkg::TRIP_WITHIN_BAND: cond = (w_s >= lo_s + hb_s) && (w_s <= hi_s - hb_s);
        default:              cond = (w_s < lo_s - hb_s) || (w_s > hi_s + hb_s);
      endcase
      if (kind == wsc_pkg::KIND_TIME) cond = (tmr >= val[i]);
      if (kind == wsc_pkg::KIND_COUNT) cond = memv[i];
      if (!memv[i]) begin
        next_sat[i] = cond;
        if (cond && !sat[i]) begin
          if (misc[i][wsc_pkg::M_CTOT]) set_tot = 1'b1;
          if (misc[i][wsc_pkg::M_CTAR]) set_tar = 1'b1;
        end
      end else if (st == wsc_pkg::WSC_RUN && i == cur && cond) begin
        if (misc[i][wsc_pkg::M_CTOT]) set_tot = 1'b1;
        if (misc[i][wsc_pkg::M_CTAR]) set_tar = 1'b1;
        if (kind == wsc_pkg::KIND_COUNT) begin
          // Loop back until the batch count is reached
          if (32'(bcnt) + 1 < 32'(val[i])) begin
            next_bcnt = bcnt + 16'h0001;
            nx = seek(memv, 0);
            next_cur = nx[4:0];
            next_tmr = 20'h00000;
          end else begin
            fin = 1'b1;
          end
        end else if (misc[i][wsc_pkg::M_CUT +: 2] == wsc_pkg::CUT_LEARN &&
                     kind != wsc_pkg::KIND_TIME) begin
          next_st = wsc_pkg::WSC_SETTLE;
          next_set_tgt = t_s;
          next_set_low = (trip == wsc_pkg::TRIP_LOWER);
          next_tmr = 20'h00000;
        end else begin
          adv = 1'b1;
        end
      end
    end

    // Settling: learn on standstill, give up at the timeout
    if (st == wsc_pkg::WSC_SETTLE) begin
      if (sample_valid && standstill) begin
        adv = 1'b1;
        if (lcnt[c] + 16'h0001 >= lrn[c]) begin
          next_lcnt[c] = 16'h0000;
          err = $signed({4'h0, weight}) - set_tgt;
          if (set_low) err = -err;
          ld = LW'(err) * LW'($signed({1'b0, fac[c]})) / FS_S;
          na = LW'($signed({1'b0, amt[c]})) + ld;
          if (na < 0) next_amt[c] = wsc_pkg::ZERO20;
          else if (na > VM_S) next_amt[c] = wsc_pkg::VAL_MAX;
          else next_amt[c] = na[VW-1:0];
        end else begin
          next_lcnt[c] = lcnt[c] + 16'h0001;
        end
      end else if (tmr >= 20'(stl[c])) begin
        adv = 1'b1;
      end
    end

    // Step to the next member, or end the batch
    if (adv) begin
      nx = seek(memv, 32'(cur) + 1);
      next_st = wsc_pkg::WSC_RUN;
      next_tmr = 20'h00000;
      if (nx[5]) next_cur = nx[4:0];
      else fin = 1'b1;
    end
    if (fin) begin
      nx = seek(memv, 0);
      next_bcnt = 16'h0000;
      next_tmr = 20'h00000;
      next_cur = nx[4:0];
      next_st = (mode == wsc_pkg::MODE_AUTO) ? wsc_pkg::WSC_RUN : wsc_pkg::WSC_IDLE;
    end

    // Start from idle; off mode holds the batch sequencer idle
    nx = seek(memv, 0);
    if (st == wsc_pkg::WSC_IDLE && (go || pin_ev) && mode != wsc_pkg::MODE_OFF && nx[5]) begin
      next_st = wsc_pkg::WSC_RUN;
      next_cur = nx[4:0];
      next_tmr = 20'h00000;
      next_bcnt = 16'h0000;
    end
    if (next_mode == wsc_pkg::MODE_OFF) next_st = wsc_pkg::WSC_IDLE;

    // Accumulator clear first, tare next cycle; a new request beats the clear
    next_clear_total = p_tot;
    next_clear_tare  = p_tar && !p_tot;
    next_p_tot = set_tot;
    next_p_tar = set_tar | (p_tar & p_tot);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < N; k++) begin
        val[k] <= wsc_pkg::ZERO20;
        band[k] <= wsc_pkg::ZERO20;
        hyst[k] <= wsc_pkg::ZERO20;
        amt[k] <= wsc_pkg::ZERO20;
        fac[k] <= wsc_pkg::FAC_DEF;
        stl[k] <= 16'h0000;
        lrn[k] <= wsc_pkg::LRN_DEF;
        lcnt[k] <= 16'h0000;
        refn[k] <= wsc_pkg::REF_DEF;
        misc[k] <= '0;
      end
      sat <= '0;
      mode <= wsc_pkg::MODE_OFF;
      st <= wsc_pkg::WSC_IDLE;
      cur <= 5'h00;
      scan_idx <= 5'h00;
      scan_on <= 1'b0;
      w_cap <= '0;
      tmr <= 20'h00000;
      bcnt <= 16'h0000;
      set_tgt <= '0;
      set_low <= 1'b0;
      p_tot <= 1'b0;
      p_tar <= 1'b0;
      clear_total <= 1'b0;
      clear_tare <= 1'b0;
      rdata <= 32'h00000000;
      dout_n <= '1;
      batch_busy <= 1'b0;
    end else if (ce) begin
      val <= next_val;
      band <= next_band;
      hyst <= next_hyst;
      amt <= next_amt;
      fac <= next_fac;
      stl <= next_stl;
      lrn <= next_lrn;
      lcnt <= next_lcnt;
      refn <= next_refn;
      misc <= next_misc;
      sat <= next_sat;
      mode <= next_mode;
      st <= next_st;
      cur <= next_cur;
      scan_idx <= next_scan_idx;
      scan_on <= next_scan_on;
      w_cap <= next_w_cap;
      tmr <= next_tmr;
      bcnt <= next_bcnt;
      set_tgt <= next_set_tgt;
      set_low <= next_set_low;
      p_tot <= next_p_tot;
      p_tar <= next_p_tar;
      clear_total <= next_clear_total;
      clear_tare <= next_clear_tare;
      rdata <= next_rdata;
      dout_n <= next_dout; // One cycle behind the state it shows
      batch_busy <= (st != wsc_pkg::WSC_IDLE);
    end
  end
endmodule

`default_nettype wire

//--- design/wsc_pkg.sv
// Purpose: Constants shared by the weight setpoint comparator.
// Assumes: 50 MHz system clock, register port with 9-bit word address.
// Notes:   Field indices select a word within one setpoint's block.
//
// Notes on behaviour
// - Batches run only in automatic or manual batching mode; the code also runs them in the unencoded mode value 3, which ends like manual.
// - Manual mode waits for start input or command; one run per start.
// - Automatic mode repeats batches after one start.
// - Weight target values are accepted from 0 to 999999.
// - Time setpoint values count tenth-second units, 0 to 65535.
// - Counter value is the number of consecutive batches, 0 to 65535.
// - Satisfied when above, below, inside band or outside band.
// - Higher batch trip: output active until weight reaches value.
// - Lower batch trip: output active until weight falls below value.
// - Band is value plus or minus half width, half width 0 to 999999.
// - Once off, weight must pass the hysteresis band to trip again.
// - Early cutoff releases the output before the setpoint is satisfied.
// - Early cutoff shifts trip threshold by cutoff amount, direction by trip.
// - Self tuning adds factor times settled error to cutoff amount.
// - Correction factor is a percentage, default 50.0, limited 0.0 to 100.0.
// - Self tuning waits up to settle timeout tenths for standstill.
// - Self tuning recalculates once every learn interval batches, 1 to 65535.
// - Relative target is own value percent of referenced setpoint target.
// - Each setpoint is a batch member or evaluated continuously.
// - Clear total on trip clears the accumulator when satisfied.
// - Clear tare on trip clears the stored tare when satisfied.
// - Actions run in order: clear accumulator, then clear tare.
// - Continuous setpoint drives its output low while condition is met.
// - Polarity invert flips output state; normal leaves it.

package wsc_pkg;
  localparam int          VW         = 20;
  localparam logic [19:0] VAL_MAX    = 20'hF423F;
  localparam logic [19:0] CNT_MAX    = 20'h0FFFF;
  localparam logic [9:0]  FAC_MAX    = 10'h3E8;
  localparam logic [9:0]  FAC_DEF    = 10'h1F4;
  localparam int          FSCALE     = 1000;
  localparam int          PCT        = 100;
  localparam logic [15:0] LRN_DEF    = 16'h0001;
  localparam logic [4:0]  REF_DEF    = 5'h01;
  localparam logic [19:0] ZERO20     = 20'h00000;
  // Timing
  localparam int          CLK_HZ     = 50_000_000;
  localparam int          TICK_MS    = 100;
  localparam int          TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
  // Register addressing
  localparam logic [4:0]  GLOBAL_SP  = 5'h1F;
  localparam logic [3:0]  F_VALUE    = 4'h0;
  localparam logic [3:0]  F_BAND     = 4'h1;
  localparam logic [3:0]  F_HYST     = 4'h2;
  localparam logic [3:0]  F_AMOUNT   = 4'h3;
  localparam logic [3:0]  F_FACTOR   = 4'h4;
  localparam logic [3:0]  F_SETTLE   = 4'h5;
  localparam logic [3:0]  F_LEARN    = 4'h6;
  localparam logic [3:0]  F_REF      = 4'h7;
  localparam logic [3:0]  F_MISC     = 4'h8;
  localparam logic [3:0]  G_MODE     = 4'h0;
  localparam logic [3:0]  G_START    = 4'h1;
  localparam logic [3:0]  G_STATUS   = 4'h2;
  localparam logic [3:0]  G_SAT      = 4'h3;
  // Misc word layout
  localparam int          M_KIND     = 0;
  localparam int          M_TRIP     = 2;
  localparam int          M_CUT      = 4;
  localparam int          M_MEMBER   = 6;
  localparam int          M_CTOT     = 7;
  localparam int          M_CTAR     = 8;
  localparam int          M_INV      = 9;
  localparam int          MISC_W     = 10;
  // Encodings
  localparam logic [1:0]  KIND_WEIGHT = 2'h0;
  localparam logic [1:0]  KIND_TIME   = 2'h1;
  localparam logic [1:0]  KIND_COUNT  = 2'h2;
  localparam logic [1:0]  KIND_REL    = 2'h3;
  localparam logic [1:0]  TRIP_HIGHER = 2'h0;
  localparam logic [1:0]  TRIP_LOWER  = 2'h1;
  localparam logic [1:0]  TRIP_WITHIN_BAND = 2'h2;
  localparam logic [1:0]  TRIP_OUTBND = 2'h3;
  localparam logic [1:0]  CUT_OFF     = 2'h0;
  localparam logic [1:0]  CUT_ON      = 2'h1;
  localparam logic [1:0]  CUT_LEARN   = 2'h2;
  localparam logic [1:0]  MODE_OFF    = 2'h0;
  localparam logic [1:0]  MODE_AUTO   = 2'h1;
  localparam logic [1:0]  MODE_MANUAL = 2'h2;

  typedef enum logic [1:0] {WSC_IDLE, WSC_RUN, WSC_SETTLE} wsc_state_type;
endpackage

//--- verification/wsc_asserts.sv
// Purpose: Port-level checks of the setpoint comparator.
// Assumes: One clock, synchronous reset, ce high.
// Notes:   Mode is shadowed from bus writes to the global mode word.
`timescale 1ns/1ps
`default_nettype none
module wsc_asserts #(
  parameter int N  = 20,
  parameter int WW = 24
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          ce,
  input wire logic [8:0]    addr,
  input wire logic [31:0]   wdata,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic [31:0]   rdata,
  input wire logic          sample_valid,
  input wire logic [WW-1:0] weight,
  input wire logic          standstill,
  input wire logic          batch_start_input,
  input wire logic [N-1:0]  dout_n,
  input wire logic          clear_total,
  input wire logic          clear_tare,
  input wire logic          batch_busy
);
  logic [1:0] mode;
  logic [7:0] age_smp;
  logic [7:0] age_go;
  logic       go;
  logic       sp_rd;
  assign go    = batch_start_input || (wr && addr == 9'h1F1 && wdata[0]);
  assign sp_rd = rd && (addr[8:4] < N);
  // Ages saturate instead of wrapping
  always_ff @(posedge clk) begin
    if (rst) begin
      mode    <= wsc_pkg::MODE_OFF;
      age_smp <= 8'hFF;
      age_go  <= 8'hFF;
    end else if (ce) begin
      if (wr && addr == 9'h1F0) mode <= wdata[1:0];
      age_smp <= sample_valid ? 8'h00 : age_smp + {7'h00, age_smp != 8'hFF};
      age_go  <= go ? 8'h00 : age_go + {7'h00, age_go != 8'hFF};
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rst;
    disable iff (1'b0) rst |=> &dout_n && !clear_total && !clear_tare && !batch_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_val;
    sp_rd && addr[3:0] == wsc_pkg::F_VALUE |=> rdata <= 32'h000F423F;
  endproperty
  a_val: assert property (p_val) else $error("value above limit");
  property p_fac;
    sp_rd && addr[3:0] == wsc_pkg::F_FACTOR |=> rdata <= 32'h000003E8;
  endproperty
  a_fac: assert property (p_fac) else $error("factor above limit");
  property p_lrn;
    sp_rd && addr[3:0] == wsc_pkg::F_LEARN |=> rdata inside {[32'h1:32'hFFFF]};
  endproperty
  a_lrn: assert property (p_lrn) else $error("learn range");
  property p_ref;
    sp_rd && addr[3:0] == wsc_pkg::F_REF |=> rdata inside {[1:N]};
  endproperty
  a_ref: assert property (p_ref) else $error("ref range");
  property p_off;
    mode == wsc_pkg::MODE_OFF |-> ##2 !batch_busy;
  endproperty
  a_off: assert property (p_off) else $error("run in off");
  property p_clr;
    clear_total || clear_tare |-> age_smp <= N + 4;
  endproperty
  a_clr: assert property (p_clr) else $error("stray clear");
  property p_go;
    $rose(batch_busy) && mode == wsc_pkg::MODE_MANUAL |-> age_go <= 8;
  endproperty
  a_go: assert property (p_go) else $error("unstarted run");
  c_tare: cover property (clear_tare);
  c_run: cover property ($rose(batch_busy));
  c_out: cover property (!(&dout_n));
endmodule
bind wsc_setpoint_comparator wsc_asserts #(.N(N), .WW(WW)) u_chk (.clk, .rst, .ce, .addr,
  .wdata, .wr, .rd, .rdata, .sample_valid, .weight, .standstill, .batch_start_input,
  .dout_n, .clear_total, .clear_tare, .batch_busy);
`default_nettype wire

//--- verification/wsc_weigh_model.sv
// Purpose: Weight measurement path feeding samples to the comparator.
// Assumes: Driven on the rising clock edge.
// Notes:   Between samples the lines carry the inverse.
`timescale 1ns/1ps
`default_nettype none
module wsc_weigh_model #(
  parameter int WW = 24
) (
  input  wire logic          clk,
  output logic               sample_valid,
  output logic [WW-1:0]      weight,
  output logic               standstill
);
  initial begin
    sample_valid = 1'b0;
    weight       = '0;
    standstill   = 1'b0;
  end
  // One-cycle sample pulse
  task automatic put(input logic [WW-1:0] w, input logic ss);
    @(posedge clk);
    sample_valid <= 1'b1;
    weight       <= w;
    standstill   <= ss;
    @(posedge clk);
    sample_valid <= 1'b0;
    weight       <= ~w;
    standstill   <= ~ss;
  endtask
endmodule
`default_nettype wire

//--- verification/test_wsc_setpoint_comparator.sv
// Purpose: Self-checking bench for the setpoint comparator.
// Assumes: 50 MHz clock, short tick divider.
// Notes:   Samples spaced for a full scan.
`timescale 1ns/1ps
`default_nettype none
module test_wsc_setpoint_comparator;
  localparam int N  = 20;
  localparam int WW = 24;
  localparam logic [3:0] FV = wsc_pkg::F_VALUE, FM = wsc_pkg::F_MISC, FB = wsc_pkg::F_BAND;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [8:0]    addr = 9'h000;
  logic [31:0]   wdata = 32'h00000000;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic          start = 1'b0;
  logic [31:0]   rdata;
  logic          sv;
  logic          ss;
  logic [WW-1:0] w;
  logic [N-1:0]  dout_n;
  logic          ctot;
  logic          ctar;
  logic          busy;
  int            fails = 0;
  int            n_compared = 0;
  int            cyc = 0;
  int            t_tot = 0;
  int            t_tar = 0;
  logic [WW-1:0] hw [4] = '{24'h00005A, 24'h00006E, 24'h000082, 24'h00006E};
  logic          he [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  always #10 clk = ~clk;
  wsc_weigh_model #(.WW(WW)) wm (.clk(clk), .sample_valid(sv), .weight(w), .standstill(ss));
  wsc_setpoint_comparator #(.N(N), .WW(WW), .TICK_CYCLES(10)) dut (.clk(clk), .rst(rst),
    .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sample_valid(sv), .weight(w), .standstill(ss), .batch_start_input(start),
    .dout_n(dout_n), .clear_total(ctot), .clear_tare(ctar), .batch_busy(busy));
  // Clear pulse stamps, to judge order
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ctot === 1'b1) t_tot <= cyc;
    if (ctar === 1'b1) t_tar <= cyc;
  end
  function automatic logic [8:0] ad(input logic [4:0] s, input logic [3:0] f);
    return {s, f};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [8:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  // Sample, then wait for the last output
  task automatic smp(input logic [WW-1:0] v);
    wm.put(v, 1'b0);
    repeat (N + 4) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog, far past the run's length
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("idle", 32'h1, 32'(&dout_n));
    wr_reg(ad(0, FV), 32'h00FFFFFF);
    rd_chk("value", ad(0, FV), 32'h000F423F);
    rd_chk("fac_def", ad(1, wsc_pkg::F_FACTOR), 32'h000001F4);
    wr_reg(ad(0, wsc_pkg::F_FACTOR), 32'h000007D0);
    rd_chk("factor", ad(0, wsc_pkg::F_FACTOR), 32'h000003E8);
    wr_reg(ad(0, wsc_pkg::F_LEARN), 32'h00000000);
    rd_chk("learn", ad(0, wsc_pkg::F_LEARN), 32'h00000001);
    wr_reg(ad(0, wsc_pkg::F_REF), 32'h0000001E);
    rd_chk("ref", ad(0, wsc_pkg::F_REF), 32'h00000014);
    wr_reg(ad(0, FB), 32'h000F423F);
    rd_chk("band", ad(0, FB), 32'h000F423F);
    rd_chk("unmapped", ad(25, FV), 32'h00000000);
    for (int k = 1; k < 3; k++) begin
      wr_reg(ad(5, FM), 32'(k));
      wr_reg(ad(5, FV), 32'h000FFFFF);
      rd_chk("count", ad(5, FV), 32'h0000FFFF);
    end
    wr_reg(ad(0, FV), 32'h00000064);
    wr_reg(ad(0, FM), 32'h00000180);
    smp(24'h000096);
    chk("cont", 32'h0, 32'(dout_n[0]));
    chk("order", 32'(t_tot + 1), 32'(t_tar));
    wr_reg(ad(0, FM), 32'h00000200);
    smp(24'h000096);
    chk("invert", 32'h1, 32'(dout_n[0]));
    wr_reg(ad(1, FV), 32'h00000064);
    wr_reg(ad(1, FB), 32'h0000000A);
    for (int t = 0; t < 4; t++) begin
      wr_reg(ad(1, FM), 32'(t << 2));
      smp(24'h000069);
      chk("trip_hi", 32'(t == 1 || t == 3), 32'(dout_n[1]));
      smp(24'h000050);
      chk("trip_lo", 32'(t == 0 || t == 2), 32'(dout_n[1]));
    end
    wr_reg(ad(2, FV), 32'h00000064);
    wr_reg(ad(2, wsc_pkg::F_HYST), 32'h00000014);
    foreach (hw[i]) begin
      smp(hw[i]);
      chk("hyst", 32'(he[i]), 32'(dout_n[2]));
    end
    wr_reg(ad(3, FV), 32'h00000064);
    wr_reg(ad(3, wsc_pkg::F_AMOUNT), 32'h0000000A);
    wr_reg(ad(3, FM), 32'h00000010);
    smp(24'h00005F);
    chk("cutoff", 32'h0, 32'(dout_n[3]));
    wr_reg(ad(4, FV), 32'h000000C8);
    wr_reg(ad(4, FM), 32'h00000040);
    wr_reg(9'h1F0, 32'h00000002);
    smp(24'h000064);
    chk("hold", 32'h0, 32'(busy));
    wr_reg(9'h1F1, 32'h00000001);
    smp(24'h000064);
    chk("run", 32'h1, 32'(busy));
    chk("fill", 32'h0, 32'(dout_n[4]));
    smp(24'h0000FA);
    chk("done", 32'h0, 32'(busy));
    chk("shut", 32'h1, 32'(dout_n[4]));
    @(posedge clk);
    start <= 1'b1;
    repeat (8) @(posedge clk);
    start <= 1'b0;
    #1 chk("pin", 32'h1, 32'(busy));
    wr_reg(9'h1F0, 32'h00000000);
    wr_reg(9'h1F1, 32'h00000001);
    repeat (4) @(posedge clk);
    #1 chk("off", 32'h0, 32'(busy));
    wr_reg(9'h1F0, 32'h00000001);
    wr_reg(9'h1F1, 32'h00000001);
    smp(24'h0000FA);
    smp(24'h0000FA);
    chk("auto", 32'h1, 32'(busy));
    print_verdict;
  end
endmodule
`default_nettype wire
